// [hw/dst_diag.sv]
`timescale 1ns/1ps
// Behaviour
// - auto test trigger stimulates sensor, measures, judges pass/fail, writes flag, resumes sampling
// - auto test trigger bit clears itself when the routine ends
// - manual field 10 negative stimulus, 01 positive, 00 none
// - memory trigger compares flash and SRAM checksums; result in status bit 6
// - status read clears every flag except the two supply flags
// - a persisting condition sets its flag again at the next sample cycle
// - supply flags ignore reads and drop when supply returns to range
// - bit 1 high above 5.25 V, bit 0 high below 4.75 V
// - bits 9 and 8 show alarm 2 and alarm 1 activity
// - bit 5 shows self-test failure
// - bit 4 set when the sensor exceeds its range
// - bit 3 set on serial communication failure
// - bit 2 set when a flash update fails
// - triggers and stimulus live in misc_control upper byte; reset value 0x0006
module dst_diag #(
  parameter logic [7:0] SETTLE_COUNT = dst_pkg::SETTLE_SAMPLES,
  parameter logic [7:0] MEM_COUNT    = dst_pkg::MEM_SAMPLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        SAMPLE_TICK,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [6:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        ALARM1_ACTIVE,
  input  wire logic        ALARM2_ACTIVE,
  input  wire logic        OVERRANGE,
  input  wire logic        LINK_FAIL,
  input  wire logic        FLASH_UPDATE_FAIL,
  input  wire logic        SUPPLY_HIGH,
  input  wire logic        SUPPLY_LOW,
  input  wire logic        SENSOR_RESPONSE_OK,
  input  wire logic        CHECKSUM_MATCH,
  output logic [15:0]      REG_RDATA,
  output logic             STIM_POS,
  output logic             STIM_NEG,
  output logic             CHECKSUM_START,
  output logic             TEST_BUSY,
  output logic [2:0]       DATA_READY_CFG
);
  import dst_pkg::*;

  // the routine is split into equal positive and negative halves
  localparam logic [7:0] HALF_COUNT = SETTLE_COUNT >> 1;

  // refuse counts that the sequencer cannot split or finish
  if (SETTLE_COUNT < 8'h02 || SETTLE_COUNT[0]) begin : g_bad_settle
    $error("settle count must be even and at least two");
  end
  if (MEM_COUNT == 8'h00) begin : g_bad_mem
    $error("memory test count must not be zero");
  end

  typedef struct packed {
    dst_state_type state;
    logic [15:0]   misc;
    logic [15:0]   flags;
    logic [15:0]   rdata;
    logic [7:0]    count;
    logic          stim_pos;
    logic          stim_neg;
    logic          cks_start;
    logic          busy;
    logic          failed;
  } dst_regs_type;

  dst_regs_type r;
  dst_regs_type next_r;
  logic [15:0]  sticky_set;
  logic         rd_flags;
  logic         misc_wr;

  // decoded register strobes; flag events themselves wait for the tick
  assign rd_flags = REG_RD && (REG_ADDR == DIAGNOSTIC_FLAGS_ADDR);
  assign misc_wr  = REG_WR && (REG_ADDR == MISC_CONTROL_ADDR);

  always_comb begin
    next_r = r;
    sticky_set = 16'h0000;
    next_r.cks_start = 1'b0;
    // register writes; only bits 11:8 and 2:0 are kept, the rest are masked off
    if (misc_wr) begin
      next_r.misc = REG_WDATA & MC_USED_MASK;
    end
    // error conditions sampled per sample cycle
    if (SAMPLE_TICK) begin
      sticky_set[DF_ALARM2]    = ALARM2_ACTIVE;
      sticky_set[DF_ALARM1]    = ALARM1_ACTIVE;
      sticky_set[DF_OVERRANGE] = OVERRANGE;
      sticky_set[DF_LINK_FAIL] = LINK_FAIL;
      sticky_set[DF_FLASH_BAD] = FLASH_UPDATE_FAIL;
    end
    // self-test sequencer, paced by the sample tick
    case (r.state)
      ST_IDLE: begin
        next_r.busy = 1'b0;
        if (r.misc[MC_AUTO_TEST]) begin
          next_r.state = ST_STIM;
          next_r.count = SETTLE_COUNT;
          next_r.busy  = 1'b1;
          next_r.failed = 1'b0;
        end else if (r.misc[MC_MEM_TEST]) begin
          next_r.state = ST_MEM;
          next_r.count = MEM_COUNT;
          next_r.cks_start = 1'b1;
          next_r.busy  = 1'b1;
        end
      end
      ST_STIM: begin
        // positive then negative half, response is checked in the negative half only
        if (SAMPLE_TICK) begin
          next_r.count = r.count - 8'h01;
          if (!SENSOR_RESPONSE_OK && r.count <= HALF_COUNT) begin
            next_r.failed = 1'b1;
          end
          if (r.count == 8'h01) begin
            next_r.state = ST_JUDGE;
          end
        end
      end
      ST_JUDGE: begin
        if (SAMPLE_TICK) begin
          sticky_set[DF_TEST_FAIL] = r.failed;
          next_r.misc[MC_AUTO_TEST] = 1'b0;
          next_r.state = ST_IDLE;
          next_r.busy  = 1'b0;
        end
      end
      ST_MEM: begin
        if (SAMPLE_TICK) begin
          next_r.count = r.count - 8'h01;
          if (r.count == 8'h01) begin
            sticky_set[DF_MEM_FAIL] = !CHECKSUM_MATCH;
            next_r.misc[MC_MEM_TEST] = 1'b0;
            next_r.state = ST_IDLE;
            next_r.busy  = 1'b0;
          end
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
    // manual stimulus yields to the automatic routine during its stimulus phase (ST_STIM)
    if (r.state == ST_STIM) begin
      next_r.stim_pos = r.count > HALF_COUNT;
      next_r.stim_neg = r.count <= HALF_COUNT;
    end else begin
      next_r.stim_pos = next_r.misc[MC_STIM_POS] && !next_r.misc[MC_STIM_NEG];
      next_r.stim_neg = next_r.misc[MC_STIM_NEG] && !next_r.misc[MC_STIM_POS];
    end
    // read clears, new events win over the clear
    if (rd_flags) begin
      next_r.flags[15:2] = 14'h0000;
    end
    next_r.flags = (next_r.flags | sticky_set) & DF_USED_MASK;
    // supply flags track the comparators directly
    next_r.flags[DF_SUPPLY_HI] = SUPPLY_HIGH;
    next_r.flags[DF_SUPPLY_LO] = SUPPLY_LOW;
    // read data captured before the clear takes effect
    if (rd_flags) begin
      next_r.rdata = r.flags & DF_USED_MASK;
    end else if (REG_RD && REG_ADDR == MISC_CONTROL_ADDR) begin
      next_r.rdata = r.misc;
    end else if (REG_RD) begin
      next_r.rdata = 16'h0000;
    end
  end

  // single state register
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      r <= '{state: ST_IDLE, misc: MISC_CONTROL_RESET, flags: DIAG_RESET,
             rdata: 16'h0000, count: 8'h00, default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign REG_RDATA      = r.rdata;
  assign STIM_POS       = r.stim_pos;
  assign STIM_NEG       = r.stim_neg;
  assign CHECKSUM_START = r.cks_start;
  assign TEST_BUSY      = r.busy;
  assign DATA_READY_CFG = r.misc[2:0];

  // auto trigger must be clear, and the sequencer idle, in the cycle after the judging sample tick
  property p_auto_done;
    @(posedge CLK_SYS) disable iff (!NRST)
      (r.state == ST_JUDGE && SAMPLE_TICK) |=> !r.misc[MC_AUTO_TEST] && r.state == ST_IDLE;
  endproperty
  a_auto_done: assert property (p_auto_done) else $error("auto trigger not cleared");

  property p_read_clear;
    @(posedge CLK_SYS) disable iff (!NRST)
      (rd_flags && !SAMPLE_TICK && r.state != ST_JUDGE && r.state != ST_MEM)
        |=> r.flags[15:2] == 14'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

  property p_set_wins;
    @(posedge CLK_SYS) disable iff (!NRST)
      (rd_flags && SAMPLE_TICK && OVERRANGE) |=> r.flags[DF_OVERRANGE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read");

  property p_supply;
    @(posedge CLK_SYS) disable iff (!NRST)
      1'b1 |=> r.flags[1:0] == {$past(SUPPLY_HIGH), $past(SUPPLY_LOW)};
  endproperty
  a_supply: assert property (p_supply) else $error("supply flags wrong");

  property p_unused;
    @(posedge CLK_SYS) disable iff (!NRST)
      REG_RDATA[15:10] == 6'h00 && (!$past(rd_flags) || !REG_RDATA[7]);
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits set");

  property p_stim;
    @(posedge CLK_SYS) disable iff (!NRST)
      (r.state == ST_IDLE && r.misc[9:8] == 2'b10 && !r.misc[MC_AUTO_TEST] && !misc_wr)
        |=> STIM_NEG && !STIM_POS;
  endproperty
  a_stim: assert property (p_stim) else $error("negative stimulus missing");

  property p_mem;
    @(posedge CLK_SYS) disable iff (!NRST)
      (r.state == ST_MEM && SAMPLE_TICK && r.count == 8'h01 && !CHECKSUM_MATCH)
        |=> r.flags[DF_MEM_FAIL];
  endproperty
  a_mem: assert property (p_mem) else $error("checksum fail not flagged");

  property p_alarm;
    @(posedge CLK_SYS) disable iff (!NRST)
      (SAMPLE_TICK && ALARM2_ACTIVE) |=> r.flags[DF_ALARM2];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm 2 not flagged");

  property p_alarm1;
    @(posedge CLK_SYS) disable iff (!NRST)
      (SAMPLE_TICK && ALARM1_ACTIVE) |=> r.flags[DF_ALARM1];
  endproperty
  a_alarm1: assert property (p_alarm1) else $error("alarm 1 not flagged");

  property p_overrange;
    @(posedge CLK_SYS) disable iff (!NRST)
      (SAMPLE_TICK && OVERRANGE) |=> r.flags[DF_OVERRANGE];
  endproperty
  a_overrange: assert property (p_overrange) else $error("overrange not flagged");

  property p_link;
    @(posedge CLK_SYS) disable iff (!NRST)
      (SAMPLE_TICK && LINK_FAIL) |=> r.flags[DF_LINK_FAIL];
  endproperty
  a_link: assert property (p_link) else $error("link failure not flagged");

  property p_flash;
    @(posedge CLK_SYS) disable iff (!NRST)
      (SAMPLE_TICK && FLASH_UPDATE_FAIL) |=> r.flags[DF_FLASH_BAD];
  endproperty
  a_flash: assert property (p_flash) else $error("flash failure not flagged");

  property p_test_fail;
    @(posedge CLK_SYS) disable iff (!NRST)
      (r.state == ST_JUDGE && SAMPLE_TICK && r.failed) |=> r.flags[DF_TEST_FAIL];
  endproperty
  a_test_fail: assert property (p_test_fail) else $error("self-test fail not flagged");

  property p_auto_pos;
    @(posedge CLK_SYS) disable iff (!NRST)
      (r.state == ST_STIM && r.count > HALF_COUNT) |=> STIM_POS && !STIM_NEG;
  endproperty
  a_auto_pos: assert property (p_auto_pos) else $error("auto positive stimulus missing");

  property p_auto_neg;
    @(posedge CLK_SYS) disable iff (!NRST)
      (r.state == ST_STIM && r.count <= HALF_COUNT) |=> STIM_NEG && !STIM_POS;
  endproperty
  a_auto_neg: assert property (p_auto_neg) else $error("auto negative stimulus missing");

  property p_busy;
    @(posedge CLK_SYS) disable iff (!NRST)
      TEST_BUSY == (r.state != ST_IDLE);
  endproperty
  a_busy: assert property (p_busy) else $error("busy does not follow the sequencer");

  property p_cks_pulse;
    @(posedge CLK_SYS) disable iff (!NRST)
      CHECKSUM_START |-> r.state == ST_MEM ##1 !CHECKSUM_START;
  endproperty
  a_cks_pulse: assert property (p_cks_pulse) else $error("checksum start not a pulse");

  property p_mem_done;
    @(posedge CLK_SYS) disable iff (!NRST)
      (r.state == ST_MEM && SAMPLE_TICK && r.count == 8'h01)
        |=> !r.misc[MC_MEM_TEST] && r.state == ST_IDLE;
  endproperty
  a_mem_done: assert property (p_mem_done) else $error("memory trigger not cleared");

  property p_stim_pos;
    @(posedge CLK_SYS) disable iff (!NRST)
      (r.state == ST_IDLE && r.misc[9:8] == 2'b01 && !r.misc[MC_AUTO_TEST] && !misc_wr)
        |=> STIM_POS && !STIM_NEG;
  endproperty
  a_stim_pos: assert property (p_stim_pos) else $error("positive stimulus missing");
endmodule // dst_diag

// [hw/dst_pkg.sv]
package dst_pkg;
  // register map, byte addresses on the serial register port
  localparam logic [6:0]  MISC_CONTROL_ADDR     = 7'h34;
  localparam logic [6:0]  DIAGNOSTIC_FLAGS_ADDR = 7'h3C;
  localparam logic [15:0] MISC_CONTROL_RESET    = 16'h0006;
  localparam logic [15:0] DIAG_RESET            = 16'h0000;
  // misc_control field positions
  localparam int MC_MEM_TEST  = 11;
  localparam int MC_AUTO_TEST = 10;
  localparam int MC_STIM_NEG  = 9;
  localparam int MC_STIM_POS  = 8;
  // diagnostic_flags field positions
  localparam int DF_ALARM2    = 9;
  localparam int DF_ALARM1    = 8;
  localparam int DF_MEM_FAIL  = 6;
  localparam int DF_TEST_FAIL = 5;
  localparam int DF_OVERRANGE = 4;
  localparam int DF_LINK_FAIL = 3;
  localparam int DF_FLASH_BAD = 2;
  localparam int DF_SUPPLY_HI = 1;
  localparam int DF_SUPPLY_LO = 0;
  // bits that exist; all others read zero
  localparam logic [15:0] DF_USED_MASK = 16'h037F;
  localparam logic [15:0] MC_USED_MASK = 16'h0F07;
  // automatic self-test and memory test timing, in sample cycles
  localparam logic [7:0] SETTLE_SAMPLES = 8'h08;
  localparam logic [7:0] MEM_SAMPLES    = 8'h04;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_STIM  = 2'b01,
    ST_JUDGE = 2'b11,
    ST_MEM   = 2'b10
  } dst_state_type;
endpackage

// [verif/dst_host.sv]
`timescale 1ns/1ps
// register master on the serial register port
module dst_host (
  input  wire logic        CLK_SYS,
  output logic             REG_WR,
  output logic             REG_RD,
  output logic [6:0]       REG_ADDR,
  output logic [15:0]      REG_WDATA
);
  // idle port at time zero
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 7'h00;
    REG_WDATA = 16'h0000;
  end
  // held over one rising edge, then data inverted so no stale value lingers
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK_SYS);
    REG_WR = 1'b0;
    REG_WDATA = ~d;
  endtask
  // one read strobe; answer is sampled by the bench monitor
  task automatic rd(input logic [6:0] a);
    @(negedge CLK_SYS);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK_SYS);
    REG_RD = 1'b0;
  endtask
endmodule // dst_host

// [verif/diagnostic_self_test_status_bench.sv]
`timescale 1ns/1ps
module diagnostic_self_test_status_bench;
  import dst_pkg::*;
  logic CLK_SYS = 1'b0, NRST = 1'b0, SAMPLE_TICK = 1'b0, REG_WR, REG_RD;
  logic ALARM1_ACTIVE = 0, ALARM2_ACTIVE = 0, OVERRANGE = 0, LINK_FAIL = 0;
  logic FLASH_UPDATE_FAIL = 0, SUPPLY_HIGH = 0, SUPPLY_LOW = 0;
  logic SENSOR_RESPONSE_OK = 1, CHECKSUM_MATCH = 1, STIM_POS, STIM_NEG;
  logic CHECKSUM_START, TEST_BUSY, rd_seen = 0;
  logic [6:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, e;
  logic [2:0] DATA_READY_CFG;
  logic [15:0] exp_q[$];
  logic [7:0] lfsr = 8'h37;
  logic [1:0] v;
  int num_errors = 0, samples_checked = 0, n;
  dst_host host (.CLK_SYS, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA);
  dst_diag uut (.CLK_SYS, .NRST, .SAMPLE_TICK, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
    .ALARM1_ACTIVE, .ALARM2_ACTIVE, .OVERRANGE, .LINK_FAIL, .FLASH_UPDATE_FAIL,
    .SUPPLY_HIGH, .SUPPLY_LOW, .SENSOR_RESPONSE_OK, .CHECKSUM_MATCH, .REG_RDATA,
    .STIM_POS, .STIM_NEG, .CHECKSUM_START, .TEST_BUSY, .DATA_READY_CFG);
  // 25 MHz clock
  always #20 CLK_SYS = ~CLK_SYS;
  // sample tick every fourth cycle, short so tests stay quick
  always @(negedge CLK_SYS) begin
    n <= (n + 1) % 4;
    SAMPLE_TICK <= (n == 3);
  end
  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, ex, seen);
    end
  endtask
  // read answer lands one edge after the strobe; compare against oldest note
  always @(posedge CLK_SYS) rd_seen <= REG_RD;
  always @(negedge CLK_SYS) begin
    if (rd_seen) check("read data", REG_RDATA, exp_q.pop_front());
  end
  task automatic rd(input logic [6:0] a, input logic [15:0] ex);
    exp_q.push_back(ex);
    host.rd(a);
  endtask
  // the extra edges let the tick be consumed before anything follows
  task automatic ticks(input int k);
    repeat (k) @(posedge SAMPLE_TICK);
    repeat (2) @(negedge CLK_SYS);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog, well beyond the expected run of about 320 cycles
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  initial begin
    n = 0;
    repeat (4) @(negedge CLK_SYS);
    NRST = 1'b1;
    check("ready cfg", {13'h0000, DATA_READY_CFG}, 16'h0006);
    rd(MISC_CONTROL_ADDR, 16'h0006);
    rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0000);
    rd(7'h10, 16'h0000);
    $display("reset values done");
    // random event flags; a clearing read leaves nothing behind
    repeat (4) begin
      lfsr = step(lfsr);
      {ALARM2_ACTIVE, ALARM1_ACTIVE, OVERRANGE, LINK_FAIL, FLASH_UPDATE_FAIL} = lfsr[4:0];
      ticks(1);
      {ALARM2_ACTIVE, ALARM1_ACTIVE, OVERRANGE, LINK_FAIL, FLASH_UPDATE_FAIL} = 5'h00;
      e = {6'h00, lfsr[4:3], 3'h0, lfsr[2:0], 2'h0};
      rd(DIAGNOSTIC_FLAGS_ADDR, e);
      rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0000);
    end
    ALARM1_ACTIVE = 1'b1;
    ticks(1);
    rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0100);
    ticks(1);
    ALARM1_ACTIVE = 1'b0;
    rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0100);
    ticks(1);
    rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0000);
    // read strobe lands on the tick edge while overrange persists
    OVERRANGE = 1'b1;
    ticks(1);
    @(posedge SAMPLE_TICK);
    repeat (3) @(negedge CLK_SYS);
    rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0010);
    OVERRANGE = 1'b0;
    rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0010);
    rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0000);
    $display("event flags done");
    for (int b = 0; b < 2; b++) begin
      v = 2'h1 << b;
      {SUPPLY_HIGH, SUPPLY_LOW} = v;
      ticks(1);
      rd(DIAGNOSTIC_FLAGS_ADDR, {14'h0000, v});
      rd(DIAGNOSTIC_FLAGS_ADDR, {14'h0000, v});
      {SUPPLY_HIGH, SUPPLY_LOW} = 2'h0;
      ticks(1);
      rd(DIAGNOSTIC_FLAGS_ADDR, 16'h0000);
    end
    $display("supply flags done");
    for (int k = 0; k < 3; k++) begin
      v = 2'h2 >> k;
      host.wr(MISC_CONTROL_ADDR, {6'h00, v, 8'h06});
      check("stimulus", {14'h0000, STIM_NEG, STIM_POS}, {14'h0000, v});
      // host lets the stimulus settle; it must stay applied meanwhile
      repeat (8) @(negedge CLK_SYS);
      check("stimulus held", {14'h0000, STIM_NEG, STIM_POS}, {14'h0000, v});
    end
    $display("manual stimulus done");
    // auto test with a failing then a passing sensor response
    for (int ok = 0; ok < 2; ok++) begin
      // sensor at rest: event inputs stay quiet, only the verdict varies
      SENSOR_RESPONSE_OK = ok[0];
      host.wr(MISC_CONTROL_ADDR, 16'h0406);
      @(negedge CLK_SYS);
      check("busy", {15'h0000, TEST_BUSY}, 16'h0001);
      @(negedge CLK_SYS);
      check("auto stimulus", {14'h0000, STIM_NEG, STIM_POS}, 16'h0001);
      for (int t = 0; t < 300 && TEST_BUSY !== 1'b0; t++) @(negedge CLK_SYS);
      rd(MISC_CONTROL_ADDR, 16'h0006);
      rd(DIAGNOSTIC_FLAGS_ADDR, ok ? 16'h0000 : 16'h0020);
    end
    $display("auto test done");
    for (int m = 0; m < 2; m++) begin
      CHECKSUM_MATCH = m[0];
      host.wr(MISC_CONTROL_ADDR, 16'h0806);
      @(negedge CLK_SYS);
      check("checksum start", {15'h0000, CHECKSUM_START}, 16'h0001);
      repeat (29) @(negedge CLK_SYS);
      rd(MISC_CONTROL_ADDR, 16'h0006);
      rd(DIAGNOSTIC_FLAGS_ADDR, {9'h000, ~m[0], 6'h00});
    end
    $display("memory test done");
    repeat (3) @(negedge CLK_SYS);
    give_verdict();
  end
endmodule // diagnostic_self_test_status_bench
